// File: bfcd_params.svh
// Constants for the boot failure and configuration corruption detector.
// Assumes inclusion by bare name from the design module and the checker.
`ifndef BFCD_PARAMS_SVH
`define BFCD_PARAMS_SVH

// ----------------------------------------------------------------------
// Status signatures and field positions
// ----------------------------------------------------------------------
`define BFCD_SIG_INIT_FAIL 8'h61
`define BFCD_SIG_CFG_CORRUPT 8'h41
`define BFCD_SIG_OK 8'h00
`define BFCD_BIT_READY 0
`define BFCD_BIT_ERASE_ERR 5
`define BFCD_BIT_PROG_ERR 6

// ----------------------------------------------------------------------
// Interface settings and reset values
// ----------------------------------------------------------------------
`define BFCD_CORRUPT_LATENCY 5'h14
`define BFCD_DEFAULT_LATENCY 5'h08
`define BFCD_CORRUPT_ADDR_BYTES 3'h4
`define BFCD_DEFAULT_ADDR_BYTES 3'h3
`define BFCD_NV_PREDEF 8'h00
`define BFCD_NV_COUNT 5

`endif

// File: bfcd_pkg.sv
// Types shared by the detector.
// Assumes bfcd_params.svh is available on the include path.
package bfcd_pkg;

  typedef enum logic [2:0]
  {
    BFCD_POWERUP,
    BFCD_NORMAL,
    BFCD_INIT_FAIL,
    BFCD_CORRUPT,
    BFCD_UPDATING
  } bfcd_state_e;

  typedef enum logic
  {
    BFCD_IF_X1,
    BFCD_IF_X8
  } bfcd_iface_e;

endpackage : bfcd_pkg

// File: bfcd_core.sv
// Power-up failure and configuration corruption detector of the flash.
// Assumes synchronous event strobes from the command decoder and pins.
`timescale 1ns/10ps
`include "bfcd_params.svh"

module bfcd_core
  import bfcd_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Boot strap and power-up results
  input wire logic boot_octal,
  input wire logic init_done,
  input wire logic init_failed,
  input wire logic cfg_corrupt_seen,
  // Register update activity
  input wire logic nv_erase_start,
  input wire logic nv_write_start,
  input wire logic nv_update_done,
  input wire logic [2:0] nv_write_sel,
  input wire logic [7:0] nv_write_data,
  input wire logic hw_reset_req,
  // Host transaction request
  input wire logic host_txn_valid,
  input wire logic host_txn_is_status,
  input wire logic [7:0] prot_scheme_in,
  // Outputs
  output logic reset_done_out_n,
  output logic [7:0] volatile_status_one,
  output logic iface_octal,
  output logic host_txn_accept,
  output logic [4:0] read_latency,
  output logic [2:0] addr_bytes,
  output logic full_speed,
  output logic [7:0] prot_scheme,
  output logic [7:0] nv_reg0,
  output logic [7:0] nv_reg1,
  output logic [7:0] nv_reg2,
  output logic [7:0] nv_reg3,
  output logic [7:0] nv_reg4
);

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  typedef struct packed
  {
    bfcd_state_e state;
    bfcd_iface_e iface;
    logic boot_octal_lat;
    logic upd_is_erase;
    logic reset_done;
    logic first_nv_write_done;
    logic txn_accept;
    logic [7:0] status;
    logic [4:0] latency;
    logic [2:0] abytes;
    logic fast;
    logic [7:0] prot;
    // Five register images, lowest register in the low byte
    logic [`BFCD_NV_COUNT*8-1:0] nv;
  } bfcd_regs_s;

  bfcd_regs_s r_q;
  bfcd_regs_s r_d;

  // --------------------------------------------------------------------
  // Strap synchroniser
  // --------------------------------------------------------------------
  // Strap pin comes from outside the clock domain
  logic strap_s1_q;
  logic strap_s2_q;

  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      strap_s1_q <= 1'b0;
      strap_s2_q <= 1'b0;
    end
    else
    begin
      strap_s1_q <= boot_octal;
      strap_s2_q <= strap_s1_q;
    end
  end

  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  // Ready flag sits inside the status byte, so both update edges go through here
  function automatic logic [7:0] bfcd_set_ready(input logic [7:0] stat, input logic rdy);
    logic [7:0] res;
    res = stat;
    res[`BFCD_BIT_READY] = rdy;
    return res;
  endfunction : bfcd_set_ready

  // A cut update leaves the image suspect; an erase cut over octal is also a
  // program failure, which the host must see before it writes again
  function automatic logic [7:0] bfcd_cut_status(input logic was_erase, input logic on_octal);
    logic [7:0] res;
    res = `BFCD_SIG_CFG_CORRUPT;
    if (was_erase && on_octal)
    begin
      res[`BFCD_BIT_PROG_ERR] = 1'b1;
    end
    return res;
  endfunction : bfcd_cut_status

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb
  begin
    r_d = r_q;
    r_d.txn_accept = 1'b0;
    case (r_q.state)
      BFCD_POWERUP:
      begin
        // Strap is caught while the power-up sequence runs, not under reset
        r_d.boot_octal_lat = strap_s2_q;
        r_d.iface = strap_s2_q ? BFCD_IF_X8 : BFCD_IF_X1;
        // Failure outranks a done seen in the same cycle
        if (init_failed)
        begin
          r_d.state = BFCD_INIT_FAIL;
          r_d.reset_done = 1'b0;
          if (strap_s2_q)
          begin
            r_d.iface = BFCD_IF_X8;
          end
          else
          begin
            r_d.iface = BFCD_IF_X1;
            r_d.status = `BFCD_SIG_INIT_FAIL;
          end
        end
        else if (init_done && cfg_corrupt_seen)
        begin
          r_d.state = BFCD_CORRUPT;
          r_d.reset_done = 1'b1;
          r_d.status = `BFCD_SIG_CFG_CORRUPT;
          if (strap_s2_q)
          begin
            r_d.latency = `BFCD_CORRUPT_LATENCY;
          end
          else
          begin
            // x1 recovery runs 4-byte addresses at full clock
            r_d.iface = BFCD_IF_X1;
            r_d.abytes = `BFCD_CORRUPT_ADDR_BYTES;
            r_d.fast = 1'b1;
          end
          r_d.prot = prot_scheme_in;
          // Recovery starts a fresh first-write window
          r_d.first_nv_write_done = 1'b0;
        end
        else if (init_done)
        begin
          r_d.state = BFCD_NORMAL;
          r_d.reset_done = 1'b1;
          r_d.status = `BFCD_SIG_OK;
          r_d.prot = prot_scheme_in;
          // A clean boot drops recovery settings left over from a hardware reset
          r_d.latency = `BFCD_DEFAULT_LATENCY;
          r_d.abytes = `BFCD_DEFAULT_ADDR_BYTES;
          r_d.fast = 1'b0;
        end
      end
      BFCD_INIT_FAIL:
      begin
        // Only a hardware reset leaves this state; only x1 status requests are accepted
        r_d.reset_done = 1'b0;
        r_d.iface = r_q.boot_octal_lat ? BFCD_IF_X8 : BFCD_IF_X1;
        r_d.txn_accept = r_q.boot_octal_lat ? 1'b0 : (host_txn_valid && host_txn_is_status);
        if (hw_reset_req)
        begin
          r_d.state = BFCD_POWERUP;
        end
      end
      BFCD_NORMAL, BFCD_CORRUPT:
      begin
        r_d.txn_accept = host_txn_valid;
        // Hardware reset outranks an update request in the same cycle
        if (hw_reset_req)
        begin
          r_d.state = BFCD_POWERUP;
          r_d.reset_done = 1'b0;
        end
        else if (nv_erase_start || nv_write_start)
        begin
          r_d.state = BFCD_UPDATING;
          r_d.upd_is_erase = nv_erase_start;
          r_d.status = bfcd_set_ready(r_q.status, 1'b0);
        end
      end
      BFCD_UPDATING:
      begin
        if (hw_reset_req)
        begin
          // Update cut short: abort and fall back; contents suspect
          r_d.state = BFCD_POWERUP;
          r_d.reset_done = 1'b0;
          r_d.status = bfcd_cut_status(r_q.upd_is_erase, r_q.iface == BFCD_IF_X8);
        end
        else if (nv_update_done)
        begin
          // Back to normal; a corrupt boot keeps its recovery interface settings
          r_d.state = BFCD_NORMAL;
          r_d.status = bfcd_set_ready(r_q.status, 1'b1);
          // An erase finishing writes no byte and does not count as the first write
          if (!r_q.upd_is_erase)
          begin
            if (!r_q.first_nv_write_done)
            begin
              r_d.first_nv_write_done = 1'b1;
              r_d.nv = {`BFCD_NV_COUNT{`BFCD_NV_PREDEF}};
            end
            // Selects past the last register are dropped rather than wrapped
            if (nv_write_sel < 3'(`BFCD_NV_COUNT))
            begin
              r_d.nv[nv_write_sel*8 +: 8] = nv_write_data;
            end
          end
        end
      end
      default:
      begin
        // Unused codes fall back to power-up
        r_d.state = BFCD_POWERUP;
      end
    endcase
  end

  // --------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      // Constants only; the strap is picked up after release
      r_q.state <= BFCD_POWERUP;
      r_q.iface <= BFCD_IF_X1;
      r_q.boot_octal_lat <= 1'b0;
      r_q.upd_is_erase <= 1'b0;
      r_q.reset_done <= 1'b0;
      r_q.first_nv_write_done <= 1'b0;
      r_q.txn_accept <= 1'b0;
      r_q.status <= `BFCD_SIG_OK;
      r_q.latency <= `BFCD_DEFAULT_LATENCY;
      r_q.abytes <= `BFCD_DEFAULT_ADDR_BYTES;
      r_q.fast <= 1'b0;
      r_q.prot <= 8'h00;
      r_q.nv <= {`BFCD_NV_COUNT{`BFCD_NV_PREDEF}};
    end
    else
    begin
      r_q <= r_d;
    end
  end

  // --------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------
  // Plain wires from the state register, so every output is a flop
  assign reset_done_out_n = r_q.reset_done;
  assign volatile_status_one = r_q.status;
  assign iface_octal = (r_q.iface == BFCD_IF_X8);
  assign host_txn_accept = r_q.txn_accept;
  assign read_latency = r_q.latency;
  assign addr_bytes = r_q.abytes;
  assign full_speed = r_q.fast;
  assign prot_scheme = r_q.prot;
  assign nv_reg0 = r_q.nv[7:0];
  assign nv_reg1 = r_q.nv[15:8];
  assign nv_reg2 = r_q.nv[23:16];
  assign nv_reg3 = r_q.nv[31:24];
  assign nv_reg4 = r_q.nv[39:32];

endmodule : bfcd_core

// File: bfcd_host.sv
// Host controller model: one transaction request per bench call, notes acceptance.
// Assumes the bench spaces its requests at least four cycles apart.
`timescale 1ns/10ps
module bfcd_host
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Bench control
  input wire logic req,
  input wire logic kind,
  // Device side
  input wire logic host_txn_accept,
  output logic seen,
  output logic host_txn_valid,
  output logic host_txn_is_status
);
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      {seen, host_txn_valid, host_txn_is_status} <= 3'h0;
    else
    begin
      host_txn_valid <= req;
      // Qualifier toggles while idle so a stale value is never trusted
      host_txn_is_status <= req ? kind : ~host_txn_is_status;
      seen <= req ? 1'b0 : seen | host_txn_accept;
    end
  end
endmodule : bfcd_host

// File: bfcd_core_asserts.sv
// Checker bound to bfcd_core: power-up signatures and interrupted updates.
// Assumes single-cycle event strobes on mclk.
`timescale 1ns/10ps
`include "bfcd_params.svh"
module bfcd_core_asserts
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Power-up events
  input wire logic init_done,
  input wire logic init_failed,
  input wire logic cfg_corrupt_seen,
  input wire logic hw_reset_req,
  // Register updates
  input wire logic nv_erase_start,
  input wire logic nv_write_start,
  input wire logic nv_update_done,
  input wire logic [2:0] nv_write_sel,
  input wire logic [7:0] nv_write_data,
  // Device outputs
  input wire logic reset_done_out_n,
  input wire logic iface_octal,
  input wire logic host_txn_accept,
  input wire logic full_speed,
  input wire logic [2:0] addr_bytes,
  input wire logic [4:0] read_latency,
  input wire logic [7:0] volatile_status_one,
  input wire logic [7:0] prot_scheme,
  input wire logic [7:0] nv_reg2
);
  logic boot_bad;
  logic boot_fail;
  // Reset-done low stands for power-up or a failed boot, so only decisions made before a boot completes are judged
  assign boot_bad = !reset_done_out_n && init_done && cfg_corrupt_seen && !init_failed;
  assign boot_fail = !reset_done_out_n && init_failed;
  // Failure marks held until a hardware reset, so long holds need no open range
  logic fail_any_q;
  logic fail_oct_q;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      fail_any_q <= 1'b0;
      fail_oct_q <= 1'b0;
    end
    else if (hw_reset_req)
    begin
      fail_any_q <= 1'b0;
      fail_oct_q <= 1'b0;
    end
    else if (boot_fail)
    begin
      fail_any_q <= 1'b1;
      fail_oct_q <= iface_octal;
    end
  end
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);
  octal_refuse_a: assert property (
    fail_oct_q |-> !host_txn_accept) else $error("octal accept");
  done_low_a: assert property (
    fail_any_q |-> !reset_done_out_n) else $error("reset done rose");
  x1_fail_sig_a: assert property (
    boot_fail && !iface_octal |=> !iface_octal && volatile_status_one == `BFCD_SIG_INIT_FAIL)
    else $error("x1 init fail status");
  corrupt_sig_a: assert property (
    boot_bad && !iface_octal |=> volatile_status_one == `BFCD_SIG_CFG_CORRUPT
    && addr_bytes == `BFCD_CORRUPT_ADDR_BYTES && full_speed) else $error("x1 corrupt setup");
  octal_latency_a: assert property (
    boot_bad && iface_octal |=> read_latency == `BFCD_CORRUPT_LATENCY) else $error("latency");
  cut_update_a: assert property (
    reset_done_out_n && (nv_write_start || nv_erase_start) ##[1:2] hw_reset_req
    |=> volatile_status_one == `BFCD_SIG_CFG_CORRUPT) else $error("cut update status");
  prot_hold_a: assert property (
    $past(reset_done_out_n) && !$past(init_done) |-> $stable(prot_scheme)) else $error("prot");
  nv_apply_a: assert property (
    $past(nv_write_start, 2) && nv_update_done && nv_write_sel == 3'h2
    |=> nv_reg2 == $past(nv_write_data)) else $error("nv write lost");
  cover property (boot_bad);
  cover property (boot_fail && iface_octal);
  cover property (nv_update_done);
endmodule : bfcd_core_asserts
bind bfcd_core bfcd_core_asserts CHK (.*);

// File: boot_failure_config_corruption_detect_bench.sv
// Bench for the detector: boot failures, corruption recovery, cut updates.
// Assumes bfcd_core, bfcd_host and the bound checker compile alongside.
`timescale 1ns/10ps
module boot_failure_config_corruption_detect_bench;
  logic mclk, rst_n, boot_octal, req, kind, seen, full_speed;
  logic init_done, init_failed, cfg_corrupt_seen, nv_erase_start;
  logic nv_write_start, nv_update_done, hw_reset_req;
  logic reset_done_out_n, iface_octal, host_txn_accept, host_txn_valid, host_txn_is_status;
  logic [6:0] evt;
  logic [2:0] nv_write_sel, addr_bytes;
  logic [4:0] read_latency;
  logic [7:0] nv_write_data, prot_scheme_in, volatile_status_one, prot_scheme;
  logic [7:0] nv_reg0, nv_reg1, nv_reg2, nv_reg3, nv_reg4;
  int fails, checks;
  assign {init_done, init_failed, cfg_corrupt_seen, nv_erase_start, nv_write_start,
    nv_update_done, hw_reset_req} = evt;
  bfcd_core DUT (.*);
  bfcd_host HOST (.*);
  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  initial
  begin
    #20000;
    fails++;
    give_verdict();
  end
  task automatic give_verdict();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    fails += int'(got !== exp);
    if (got !== exp)
      $display("ERROR %0t got %h want %h", $time, got, exp);
  endtask : chk
  // One strobe pattern for one edge; outputs read just after the taking edge
  task automatic ev(input logic [6:0] v);
    @(posedge mclk);
    evt <= v;
    @(posedge mclk);
    evt <= 7'h00;
    #1;
  endtask : ev
  task automatic boot(input logic oct);
    @(posedge mclk);
    rst_n <= 1'b0;
    boot_octal <= oct;
    repeat (8) @(posedge mclk);
    rst_n <= 1'b1;
    repeat (3) @(posedge mclk);
  endtask : boot
  task automatic txn(input logic k, input logic e);
    @(posedge mclk);
    req <= 1'b1;
    kind <= k;
    @(posedge mclk);
    req <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
    chk({7'h00, seen}, {7'h00, e});
  endtask : txn
  // One register write: select and data stand from before the start to past the done
  task automatic nvw(input logic [2:0] sel, input logic [7:0] dat);
    @(posedge mclk);
    nv_write_sel <= sel;
    nv_write_data <= dat;
    ev(7'h04);
    ev(7'h02);
  endtask : nvw
  initial
  begin
    {rst_n, boot_octal, req, kind, evt, nv_write_sel, nv_write_data} = '0;
    prot_scheme_in = 8'h5A;
    boot(1'b0);
    ev(7'h20);
    chk(volatile_status_one, 8'h61);
    chk({6'h00, reset_done_out_n, iface_octal}, 8'h00);
    txn(1'b0, 1'b0);
    txn(1'b1, 1'b1);
    boot(1'b1);
    ev(7'h20);
    txn(1'b1, 1'b0);
    chk({6'h00, reset_done_out_n, iface_octal}, 8'h01);
    boot(1'b0);
    ev(7'h40);
    nvw(3'h4, 8'h3C);
    chk(nv_reg4, 8'h3C);
    ev(7'h01);
    ev(7'h50);
    chk(volatile_status_one, 8'h41);
    chk({4'h0, full_speed, addr_bytes}, 8'h0C);
    txn(1'b0, 1'b1);
    @(posedge mclk);
    prot_scheme_in <= 8'hC3;
    nvw(3'h0, 8'h11);
    nvw(3'h2, 8'hA5);
    chk(nv_reg2, 8'hA5);
    chk(nv_reg0, 8'h11);
    chk(nv_reg1 | nv_reg3 | nv_reg4, 8'h00);
    chk(prot_scheme, 8'h5A);
    boot(1'b0);
    ev(7'h40);
    ev(7'h04);
    ev(7'h01);
    chk(volatile_status_one, 8'h41);
    boot(1'b1);
    ev(7'h40);
    chk({3'h0, read_latency}, 8'h08);
    ev(7'h08);
    ev(7'h01);
    chk(volatile_status_one, 8'h41);
    ev(7'h50);
    chk({3'h0, read_latency}, 8'h14);
    give_verdict();
  end
endmodule : boot_failure_config_corruption_detect_bench
